// [rtl/fspb_cfg.svh]
`ifndef FSPB_CFG_SVH
`define FSPB_CFG_SVH

// ****************************************
// instruction opcodes
// ****************************************
`define FSPB_OP_WREN      8'h06
`define FSPB_OP_WRDI      8'h04
`define FSPB_OP_RDSR1     8'h05
`define FSPB_OP_RDSR2     8'h35
`define FSPB_OP_RDSR3     8'h15
`define FSPB_OP_WRSR1     8'h01
`define FSPB_OP_WRSR2     8'h31
`define FSPB_OP_WRSR3     8'h11
`define FSPB_OP_SUSPEND   8'h75
`define FSPB_OP_RESUME    8'h7A
`define FSPB_OP_ENTER_4L  8'h38
`define FSPB_OP_EXIT_4L   8'hFF
`define FSPB_OP_UNLOCK    8'h39

// ****************************************
// bit positions inside each status byte
// ****************************************
`define FSPB_B1_BUSY      0
`define FSPB_B1_WEL       1
`define FSPB_B1_BP_LSB    2
`define FSPB_B1_BP_MSB    4
`define FSPB_B1_TB        5
`define FSPB_B1_SEC       6
`define FSPB_B1_PM_LOW    7
`define FSPB_B2_PM_HIGH   0
`define FSPB_B2_QE        1
`define FSPB_B2_LOCK_LSB  3
`define FSPB_B2_LOCK_MSB  5
`define FSPB_B2_CMP       6
`define FSPB_B2_SUS       7
`define FSPB_B3_WPS       2
`define FSPB_B3_DRV_LSB   5
`define FSPB_B3_DRV_MSB   6
`define FSPB_B3_HOLD_RST  7

// ****************************************
// reset (factory) values
// ****************************************
`define FSPB_RST_PM       2'h0
`define FSPB_RST_CMP      1'h0
`define FSPB_RST_SEC      1'h0
`define FSPB_RST_TB       1'h0
`define FSPB_RST_BP       3'h0
`define FSPB_RST_LOCKS    3'h0
`define FSPB_RST_QE       1'h0
`define FSPB_RST_WPS      1'h0
`define FSPB_RST_DRV      2'h3
`define FSPB_RST_HOLD_RST 1'h0

// ****************************************
// protect modes and array geometry
// ****************************************
`define FSPB_PM_SOFT      2'h0
`define FSPB_PM_HARD      2'h1
`define FSPB_PM_LOCKDOWN  2'h2
`define FSPB_ADDR_W       24
`define FSPB_LOCK_AW      9
`define FSPB_LOCK_DEPTH   286
`define FSPB_LOCK_BOT_IDX 9'h0FE
`define FSPB_LOCK_TOP_IDX 9'h10E
`define FSPB_BLK_SHIFT    5'h11
`define FSPB_SECT_SHIFT   5'h0C
`define FSPB_SECT_MAX     3'h3
`define FSPB_WBYTES_MAX   2'h2
`define FSPB_ABYTES       2'h3

`endif

// [rtl/fspb_pkg.sv]
package fspb_pkg;

    typedef enum logic [2:0] {
        FSPB_PH_CMD  = 3'h0,
        FSPB_PH_ADDR = 3'h1,
        FSPB_PH_WR   = 3'h2,
        FSPB_PH_RD   = 3'h3,
        FSPB_PH_SKIP = 3'h4
    } fspb_phase_t;

    typedef struct packed {
        logic [1:0] pm;
        logic       cmp;
        logic       sec;
        logic       tb;
        logic [2:0] bp;
        logic [2:0] locks;
        logic       qe;
        logic       protect_scheme_select;
        logic [1:0] drv;
        logic       hold_rst;
    } fspb_cfg_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic di;
        logic wp_n;
        logic hold_n;
        logic pwr_off;
    } fspb_pins_t;

endpackage : fspb_pkg

// [rtl/fspb_lock_mem.sv]
`timescale 1ns/1ps
`include "fspb_cfg.svh"

module fspb_lock_mem #(
    parameter int DEPTH = `FSPB_LOCK_DEPTH,
    parameter int AW    = `FSPB_LOCK_AW
) (
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic          set_all_i,
    input  wire logic          clr_en_i,
    input  wire logic [AW-1:0] clr_addr_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic               rd_data_o
);

    typedef struct packed {
        logic [DEPTH-1:0] bits;
        logic             rd;
    } fspb_mem_state_t;

    fspb_mem_state_t s;
    fspb_mem_state_t next_s;

    always_comb begin
        next_s = s;
        if (set_all_i) begin
            next_s.bits = '1;
        end else if (clr_en_i && (int'(clr_addr_i) < DEPTH)) begin
            next_s.bits[clr_addr_i] = 1'b0;
        end
        next_s.rd = (int'(rd_addr_i) < DEPTH) ? s.bits[rd_addr_i] : 1'b1;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data_o = s.rd;

endmodule : fspb_lock_mem

// [rtl/fspb_status_bits.sv]
`timescale 1ns/1ps
`include "fspb_cfg.svh"

module fspb_status_bits
    import fspb_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    input  wire logic                    sclk_i,
    input  wire logic                    cs_n_i,
    input  wire logic                    di_i,
    input  wire logic                    wp_n_i,
    input  wire logic                    hold_n_i,
    input  wire logic                    power_off_i,
    input  wire logic [`FSPB_ADDR_W-1:0] check_addr_i,
    output logic                         do_o,
    output logic                         do_oe_o,
    output logic                         addr_protected_o,
    output logic [7:0]                   status_second_byte_o,
    output logic [7:0]                   status_third_byte_o,
    output logic [1:0]                   drive_strength_o,
    output logic                         write_enable_latch_o,
    output logic                         suspend_flag_o,
    output logic                         four_line_command_mode_o,
    output logic                         quad_data_lines_o,
    output logic                         hold_function_active_o,
    output logic                         restart_function_active_o,
    output logic                         wp_function_active_o
);

    typedef struct packed {
        fspb_pins_t                  sync1;
        fspb_pins_t                  sync2;
        logic                        sclk_prev;
        logic                        cs_n_prev;
        fspb_phase_t                 phase;
        logic [7:0]                  shreg;
        logic [2:0]                  bitcnt;
        logic [7:0]                  opcode;
        logic [1:0]                  nbytes;
        logic [15:0]                 wbuf;
        logic [`FSPB_ADDR_W-1:0]     addr;
        logic [7:0]                  outsh;
        fspb_cfg_t                   cfg;
        logic                        write_enable_latch;
        logic                        suspend_flag;
        logic                        four_line_command_mode;
        logic                        dout;
        logic                        bp_hit;
        logic                        lock_set;
        logic                        lock_clr;
        logic [`FSPB_LOCK_AW-1:0]    lock_clr_idx;
    } fspb_state_t;

    fspb_state_t s;
    fspb_state_t next_s;
    fspb_pins_t  pins_in;
    logic        lock_rd;

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [`FSPB_LOCK_AW-1:0] lock_index(
        input logic [`FSPB_ADDR_W-1:0] a
    );
        logic [`FSPB_LOCK_AW-1:0] idx;
        if (a[23:16] == 8'h00) begin
            idx = `FSPB_LOCK_BOT_IDX + {5'h00, a[15:12]};
        end else if (a[23:16] == 8'hFF) begin
            idx = `FSPB_LOCK_TOP_IDX + {5'h00, a[15:12]};
        end else begin
            idx = {1'b0, a[23:16]} - 9'h001;
        end
        return idx;
    endfunction : lock_index

    function automatic logic bp_region_hit(
        input fspb_cfg_t               c,
        input logic [`FSPB_ADDR_W-1:0] a
    );
        logic [4:0]               shift;
        logic [`FSPB_ADDR_W-1:0]  hi_mask;
        logic                     hit;
        if (c.sec) begin
            shift = `FSPB_SECT_SHIFT
                  + ((c.bp > 3'h3) ? {2'h0, `FSPB_SECT_MAX} : ({2'h0, c.bp} - 5'h01));
        end else begin
            shift = `FSPB_BLK_SHIFT + {2'h0, c.bp};
        end
        hi_mask = 24'hFFFFFF << shift;
        if (c.bp == 3'h0) begin
            hit = 1'b0;
        end else if (c.bp == 3'h7) begin
            hit = 1'b1;
        end else if (c.tb) begin
            hit = ((a & hi_mask) == 24'h000000);
        end else begin
            hit = ((a & hi_mask) == hi_mask);
        end
        return hit ^ c.cmp;
    endfunction : bp_region_hit

    function automatic fspb_cfg_t apply_second_byte(
        input fspb_cfg_t  c,
        input logic [7:0] b,
        input logic       in_qpi
    );
        fspb_cfg_t r;
        r         = c;
        r.pm[1]   = b[`FSPB_B2_PM_HIGH];
        r.qe      = b[`FSPB_B2_QE] | (in_qpi & c.qe);
        r.locks   = c.locks | b[`FSPB_B2_LOCK_MSB:`FSPB_B2_LOCK_LSB];
        r.cmp     = b[`FSPB_B2_CMP];
        return r;
    endfunction : apply_second_byte

    // ****************************************
    // pin sampling and protocol
    // ****************************************
    assign pins_in = '{sclk: sclk_i, cs_n: cs_n_i, di: di_i, wp_n: wp_n_i,
                       hold_n: hold_n_i, pwr_off: power_off_i};

    always_comb begin
        logic hold_on;
        logic restart;
        logic rise;
        logic fall;
        logic cs_end;
        logic wr_ok;
        logic [7:0] byte_in;
        logic [7:0] sr1;
        logic [7:0] wbyte;
        hold_on  = 1'b0;
        restart  = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        cs_end   = 1'b0;
        wr_ok    = 1'b0;
        byte_in  = 8'h00;
        sr1      = 8'h00;
        wbyte    = 8'h00;
        next_s   = s;
        next_s.sync1     = pins_in;
        next_s.sync2     = s.sync1;
        next_s.sclk_prev = s.sync2.sclk;
        next_s.cs_n_prev = s.sync2.cs_n;
        next_s.lock_set  = 1'b0;
        next_s.lock_clr  = 1'b0;

        hold_on = !s.cfg.qe && !s.cfg.hold_rst && !s.sync2.hold_n;
        restart = !s.cfg.qe && s.cfg.hold_rst && !s.sync2.hold_n;
        rise    = s.sync2.sclk && !s.sclk_prev && !s.sync2.cs_n && !hold_on;
        fall    = !s.sync2.sclk && s.sclk_prev && !s.sync2.cs_n && !hold_on;
        cs_end  = s.sync2.cs_n && !s.cs_n_prev;
        byte_in = {s.shreg[6:0], s.sync2.di};

        unique case (s.cfg.pm)
            `FSPB_PM_SOFT: wr_ok = s.write_enable_latch;
            `FSPB_PM_HARD: wr_ok = s.write_enable_latch && (s.sync2.wp_n || s.cfg.qe);
            default:       wr_ok = 1'b0;
        endcase

        sr1 = {s.cfg.pm[0], s.cfg.sec, s.cfg.tb, s.cfg.bp, s.write_enable_latch, 1'b0};

        if (rise) begin
            next_s.shreg  = byte_in;
            next_s.bitcnt = s.bitcnt + 3'h1;
            if (s.bitcnt == 3'h7) begin
                unique case (s.phase)
                    FSPB_PH_CMD: begin
                        next_s.opcode = byte_in;
                        next_s.phase  = FSPB_PH_SKIP;
                        unique case (byte_in)
                            `FSPB_OP_WREN:    next_s.write_enable_latch = 1'b1;
                            `FSPB_OP_WRDI:    next_s.write_enable_latch = 1'b0;
                            `FSPB_OP_SUSPEND: next_s.suspend_flag = 1'b1;
                            `FSPB_OP_RESUME:  next_s.suspend_flag = 1'b0;
                            `FSPB_OP_ENTER_4L: next_s.four_line_command_mode = s.cfg.qe;
                            `FSPB_OP_EXIT_4L: next_s.four_line_command_mode = 1'b0;
                            `FSPB_OP_RDSR1: begin
                                next_s.phase = FSPB_PH_RD;
                                next_s.outsh = sr1;
                            end
                            `FSPB_OP_RDSR2: begin
                                next_s.phase = FSPB_PH_RD;
                                next_s.outsh = status_second_byte_o;
                            end
                            `FSPB_OP_RDSR3: begin
                                next_s.phase = FSPB_PH_RD;
                                next_s.outsh = status_third_byte_o;
                            end
                            `FSPB_OP_WRSR1,
                            `FSPB_OP_WRSR2,
                            `FSPB_OP_WRSR3:   next_s.phase = FSPB_PH_WR;
                            `FSPB_OP_UNLOCK:  next_s.phase = FSPB_PH_ADDR;
                            default:          next_s.phase = FSPB_PH_SKIP;
                        endcase
                    end
                    FSPB_PH_WR: begin
                        if (s.nbytes != `FSPB_WBYTES_MAX) begin
                            next_s.wbuf   = {s.wbuf[7:0], byte_in};
                            next_s.nbytes = s.nbytes + 2'h1;
                        end
                    end
                    FSPB_PH_ADDR: begin
                        if (s.nbytes != `FSPB_ABYTES) begin
                            next_s.addr   = {s.addr[15:0], byte_in};
                            next_s.nbytes = s.nbytes + 2'h1;
                        end
                    end
                    FSPB_PH_RD, FSPB_PH_SKIP: begin
                        next_s.phase = s.phase;
                    end
                endcase
            end
        end

        if (fall && (s.phase == FSPB_PH_RD)) begin
            next_s.dout  = s.outsh[7];
            next_s.outsh = {s.outsh[6:0], s.outsh[7]};
        end

        // ****************************************
        // commit at end of frame
        // ****************************************
        if (cs_end) begin
            if ((s.phase == FSPB_PH_WR) && (s.nbytes != 2'h0)) begin
                next_s.write_enable_latch = 1'b0;
                if (wr_ok) begin
                    wbyte = (s.nbytes == 2'h2) ? s.wbuf[15:8] : s.wbuf[7:0];
                    unique case (s.opcode)
                        `FSPB_OP_WRSR1: begin
                            next_s.cfg.pm[0] = wbyte[`FSPB_B1_PM_LOW];
                            next_s.cfg.sec   = wbyte[`FSPB_B1_SEC];
                            next_s.cfg.tb    = wbyte[`FSPB_B1_TB];
                            next_s.cfg.bp    = wbyte[`FSPB_B1_BP_MSB:`FSPB_B1_BP_LSB];
                            if (s.nbytes == 2'h2) begin
                                next_s.cfg = apply_second_byte(next_s.cfg, s.wbuf[7:0],
                                                               s.four_line_command_mode);
                            end
                        end
                        `FSPB_OP_WRSR2: begin
                            next_s.cfg = apply_second_byte(s.cfg, wbyte, s.four_line_command_mode);
                        end
                        default: begin
                            next_s.cfg.protect_scheme_select      = wbyte[`FSPB_B3_WPS];
                            next_s.cfg.drv      = wbyte[`FSPB_B3_DRV_MSB:`FSPB_B3_DRV_LSB];
                            next_s.cfg.hold_rst = wbyte[`FSPB_B3_HOLD_RST];
                        end
                    endcase
                end
            end
            if ((s.opcode == `FSPB_OP_UNLOCK) && (s.nbytes == `FSPB_ABYTES)
                && (s.phase == FSPB_PH_ADDR)) begin
                next_s.write_enable_latch          = 1'b0;
                next_s.lock_clr     = s.write_enable_latch;
                next_s.lock_clr_idx = lock_index(s.addr);
            end
        end

        if (s.sync2.cs_n || restart || s.sync2.pwr_off) begin
            next_s.phase  = FSPB_PH_CMD;
            next_s.bitcnt = 3'h0;
            next_s.nbytes = 2'h0;
            next_s.dout   = 1'b0;
        end
        if (s.sync2.cs_n) begin
            next_s.opcode = 8'h00;
        end

        if (restart || s.sync2.pwr_off) begin
            next_s.write_enable_latch      = 1'b0;
            next_s.four_line_command_mode      = 1'b0;
            next_s.lock_set = 1'b1;
            next_s.lock_clr = 1'b0;
        end
        if (s.sync2.pwr_off) begin
            next_s.suspend_flag = 1'b0;
            if (s.cfg.pm == `FSPB_PM_LOCKDOWN) begin
                next_s.cfg.pm = `FSPB_PM_SOFT;
            end
        end

        next_s.bp_hit = bp_region_hit(s.cfg, check_addr_i);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s              <= '0;
            s.sync1        <= '{sclk: 1'b0, cs_n: 1'b1, di: 1'b0, wp_n: 1'b1,
                                hold_n: 1'b1, pwr_off: 1'b0};
            s.sync2        <= '{sclk: 1'b0, cs_n: 1'b1, di: 1'b0, wp_n: 1'b1,
                                hold_n: 1'b1, pwr_off: 1'b0};
            s.cs_n_prev    <= 1'b1;
            s.phase        <= FSPB_PH_CMD;
            s.cfg          <= '{pm: `FSPB_RST_PM, cmp: `FSPB_RST_CMP, sec: `FSPB_RST_SEC,
                                tb: `FSPB_RST_TB, bp: `FSPB_RST_BP, locks: `FSPB_RST_LOCKS,
                                qe: `FSPB_RST_QE, protect_scheme_select: `FSPB_RST_WPS, drv: `FSPB_RST_DRV,
                                hold_rst: `FSPB_RST_HOLD_RST};
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // block lock store
    // ****************************************
    fspb_lock_mem #(
        .DEPTH (`FSPB_LOCK_DEPTH),
        .AW    (`FSPB_LOCK_AW)
    ) u_lock_mem (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .set_all_i  (s.lock_set),
        .clr_en_i   (s.lock_clr),
        .clr_addr_i (s.lock_clr_idx),
        .rd_addr_i  (lock_index(check_addr_i)),
        .rd_data_o  (lock_rd)
    );

    // ****************************************
    // outputs
    // ****************************************
    // field or individual locks
    assign addr_protected_o = s.cfg.protect_scheme_select ? lock_rd : s.bp_hit;
    assign status_second_byte_o = {s.suspend_flag, s.cfg.cmp, s.cfg.locks, 1'b0, s.cfg.qe,
                                   s.cfg.pm[1]};
    assign status_third_byte_o  = {s.cfg.hold_rst, s.cfg.drv, 2'h0, s.cfg.protect_scheme_select, 2'h0};
    assign drive_strength_o          = s.cfg.drv;
    assign write_enable_latch_o      = s.write_enable_latch;
    assign suspend_flag_o            = s.suspend_flag;
    assign four_line_command_mode_o  = s.four_line_command_mode;
    assign quad_data_lines_o         = s.cfg.qe;
    assign wp_function_active_o      = !s.cfg.qe;
    assign hold_function_active_o    = !s.cfg.qe && !s.cfg.hold_rst;
    assign restart_function_active_o = !s.cfg.qe && s.cfg.hold_rst;
    assign do_o    = s.dout;
    assign do_oe_o = (s.phase == FSPB_PH_RD) && !s.sync2.cs_n
                     && !(hold_function_active_o && !s.sync2.hold_n);

endmodule : fspb_status_bits

// [tb/fspb_host_model.sv]
`timescale 1ns/1ps
module fspb_host_model (
    input  wire logic do_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      di_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        di_o   = 1'b0;
    end
    // one frame: opcode, n data bytes, read byte shifted in after opcode
    task automatic xfer(input logic [7:0] op, d0, d1, input int n, output logic [7:0] rd);
        logic [31:0] q;
        q  = {op, d0, d1, 8'h00};
        rd = 8'h00;
        cs_n_o <= 1'b0;
        #62.5;
        for (int i = 0; i < 8 * (n + 1); i++) begin
            di_o <= q[31-i];
            #62.5;
            sclk_o <= 1'b1;
            if (i >= 8) rd = {rd[6:0], do_i};
            #62.5;
            sclk_o <= 1'b0;
        end
        #62.5;
        cs_n_o <= 1'b1;
        di_o   <= ~di_o;
        #250;
    endtask : xfer
endmodule : fspb_host_model

// [tb/fspb_status_bits_sva.sv]
`timescale 1ns/1ps
module fspb_status_bits_sva (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       power_off_i,
    input  wire logic [7:0] status_second_byte_o,
    input  wire logic [7:0] status_third_byte_o,
    input  wire logic [1:0] drive_strength_o,
    input  wire logic       write_enable_latch_o,
    input  wire logic       suspend_flag_o,
    input  wire logic       four_line_command_mode_o,
    input  wire logic       quad_data_lines_o,
    input  wire logic       hold_function_active_o,
    input  wire logic       restart_function_active_o,
    input  wire logic       wp_function_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_drive_field_echo: assert property (drive_strength_o == status_third_byte_o[6:5])
        else $error("drive output differs from field");
    a_reserved_read_zero: assert property ({status_second_byte_o[2],
        status_third_byte_o[4:3], status_third_byte_o[1:0]} == 5'h00)
        else $error("reserved bit set");
    a_quad_pin_select: assert property (wp_function_active_o == !quad_data_lines_o
        && quad_data_lines_o == status_second_byte_o[1]) else $error("pin function wrong");
    a_hold_restart_pick: assert property (hold_function_active_o == (!quad_data_lines_o &&
        !status_third_byte_o[7]) && restart_function_active_o == (!quad_data_lines_o &&
        status_third_byte_o[7])) else $error("hold or restart function wrong");
    a_lock_bits_sticky: assert property (1 |=> (status_second_byte_o[5:3] &
        $past(status_second_byte_o[5:3])) == $past(status_second_byte_o[5:3]))
        else $error("lock bit returned to zero");
    a_four_line_qe: assert property (four_line_command_mode_o |-> quad_data_lines_o)
        else $error("quad enable low in four-line mode");
    a_enter_needs_qe: assert property ($rose(four_line_command_mode_o) |->
        $past(quad_data_lines_o)) else $error("four-line mode entered without quad enable");
    a_mode_high_held: assert property ($fell(status_second_byte_o[0]) |-> $past(power_off_i)
        || $past(power_off_i, 2) || $past(power_off_i, 3)) else $error("lock mode left early");
    a_power_clears: assert property (power_off_i [*2] |-> ##2 (!suspend_flag_o &&
        !write_enable_latch_o && !four_line_command_mode_o))
        else $error("power cycle kept flags");
endmodule : fspb_status_bits_sva
bind fspb_status_bits fspb_status_bits_sva i_sva (.clk_i(clk_i), .reset_i(reset_i),
    .power_off_i(power_off_i), .status_second_byte_o(status_second_byte_o),
    .status_third_byte_o(status_third_byte_o), .drive_strength_o(drive_strength_o),
    .write_enable_latch_o(write_enable_latch_o), .suspend_flag_o(suspend_flag_o),
    .four_line_command_mode_o(four_line_command_mode_o), .quad_data_lines_o(quad_data_lines_o),
    .hold_function_active_o(hold_function_active_o), .wp_function_active_o(wp_function_active_o),
    .restart_function_active_o(restart_function_active_o));

// [tb/test_fspb_status_bits.sv]
`timescale 1ns/1ps
module test_fspb_status_bits
    import fspb_pkg::*;
;
    logic clk_i = 0, reset_i = 1, wp_n_i = 1, hold_n_i = 1, power_off_i = 0;
    logic sclk, cs_n, di, do_o, prot, write_enable_latch, suspend_flag, four_line_command_mode;
    logic [23:0] addr = 24'h0;
    logic [7:0]  b2, b3, r;
    logic [1:0]  drv;
    int failures = 0, n_compared = 0;
    always #5 clk_i = ~clk_i;
    fspb_host_model i_host (.do_i(do_o), .sclk_o(sclk), .cs_n_o(cs_n), .di_o(di));
    fspb_status_bits i_dut (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .di_i(di), .wp_n_i(wp_n_i), .hold_n_i(hold_n_i), .power_off_i(power_off_i),
        .check_addr_i(addr), .do_o(do_o), .do_oe_o(), .addr_protected_o(prot),
        .status_second_byte_o(b2), .status_third_byte_o(b3), .drive_strength_o(drv),
        .write_enable_latch_o(write_enable_latch), .suspend_flag_o(suspend_flag), .four_line_command_mode_o(four_line_command_mode),
        .quad_data_lines_o(), .hold_function_active_o(), .restart_function_active_o(),
        .wp_function_active_o());
    task check(input logic [23:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task cmd(input logic [7:0] op);
        i_host.xfer(op, 8'h00, 8'h00, 0, r);
    endtask : cmd
    task wr(input logic [7:0] op, d0, d1, input int n);
        cmd(8'h06);
        i_host.xfer(op, d0, d1, n, r);
    endtask : wr
    task pchk(input logic [23:0] a, input logic e);
        @(posedge clk_i) addr <= a;
        repeat (3) @(posedge clk_i);
        check(prot, e, "protected");
    endtask : pchk
    task pwr;
        @(posedge clk_i) power_off_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        power_off_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : pwr
    task t_reset;
        check(b3, 8'h60, "byte3");
        pchk(24'h800000, 1'b0);
        i_host.xfer(8'h35, 8'h00, 8'h00, 1, r);
        check(r, 8'h00, "read2");
    endtask : t_reset
    task t_protect;
        wr(8'h01, 8'h04, 8'h00, 2);
        pchk(24'hFC0000, 1'b1);
        pchk(24'hFBFFFF, 1'b0);
        wr(8'h01, 8'h44, 8'h00, 2);
        pchk(24'hFFF000, 1'b1);
        pchk(24'hFFEFFF, 1'b0);
        wr(8'h31, 8'h40, 8'h00, 1);
        pchk(24'hFFF000, 1'b0);
        pchk(24'h000000, 1'b1);
        i_host.xfer(8'h35, 8'h00, 8'h00, 1, r);
        check(r, 8'h40, "read2");
    endtask : t_protect
    task t_modes;
        cmd(8'h38);
        check(four_line_command_mode, 1'b0, "four line");
        i_host.xfer(8'h31, 8'h42, 8'h00, 1, r);
        check(b2, 8'h40, "byte2");
        wr(8'h01, 8'h80, 8'h40, 2);
        i_host.xfer(8'h05, 8'h00, 8'h00, 1, r);
        check(r, 8'h80, "read1");
        @(posedge clk_i) wp_n_i <= 1'b0;
        wr(8'h31, 8'h42, 8'h00, 1);
        check(b2, 8'h40, "byte2");
        @(posedge clk_i) wp_n_i <= 1'b1;
        wr(8'h31, 8'h42, 8'h00, 1);
        check(b2, 8'h42, "byte2");
        cmd(8'h38);
        check(four_line_command_mode, 1'b1, "four line");
        wr(8'h31, 8'h40, 8'h00, 1);
        check(b2, 8'h42, "byte2");
        pwr;
        cmd(8'h75);
        check(suspend_flag, 1'b1, "suspend");
        cmd(8'h7A);
        check(suspend_flag, 1'b0, "suspend");
        cmd(8'h75);
        pwr;
        check(suspend_flag, 1'b0, "suspend");
    endtask : t_modes
    task t_lockdown;
        wr(8'h01, 8'h00, 8'h43, 2);
        wr(8'h31, 8'h40, 8'h00, 1);
        check(b2, 8'h43, "byte2");
        pwr;
        check(b2, 8'h42, "byte2");
        wr(8'h31, 8'h4A, 8'h00, 1);
        wr(8'h31, 8'h56, 8'h00, 1);
        check(b2, 8'h5A, "byte2");
    endtask : t_lockdown
    task t_pins;
        wr(8'h31, 8'h48, 8'h00, 1);
        check(b2, 8'h58, "byte2");
        @(posedge clk_i) hold_n_i <= 1'b0;
        cmd(8'h06);
        check(write_enable_latch, 1'b0, "latch");
        @(posedge clk_i) hold_n_i <= 1'b1;
        wr(8'h11, 8'hE0, 8'h00, 1);
        check(b3, 8'hE0, "byte3");
        cmd(8'h06);
        check(write_enable_latch, 1'b1, "latch");
        @(posedge clk_i) hold_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check(write_enable_latch, 1'b0, "latch");
        hold_n_i <= 1'b1;
        wr(8'h11, 8'h64, 8'h00, 1);
        wr(8'h39, 8'h40, 8'h00, 3);
        pchk(24'h400000, 1'b0);
        pchk(24'h410000, 1'b1);
    endtask : t_pins
    task t_third;
        for (int d = 0; d < 4; d++) begin
            wr(8'h11, {1'b0, d[1:0], 5'h1B}, 8'h00, 1);
            check(b3, {1'b0, d[1:0], 5'h00}, "byte3");
            check(drv, d[1:0], "drive");
        end
        i_host.xfer(8'h15, 8'h00, 8'h00, 1, r);
        check(r, 8'h60, "read3");
        wr(8'h31, 8'h1A, 8'h00, 1);
        pchk(24'h800000, 1'b0);
        wr(8'h11, 8'h04, 8'h00, 1);
        pchk(24'h800000, 1'b1);
        wr(8'h01, 8'h80, 8'h1B, 2);
        pwr;
        wr(8'h31, 8'h00, 8'h00, 1);
        check(b2, 8'h1B, "byte2");
    endtask : t_third
    task results;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        #300us;
        failures++;
        results;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        t_reset;
        t_protect;
        t_modes;
        t_lockdown;
        t_pins;
        t_third;
        results;
    end
endmodule : test_fspb_status_bits
